// >>> logic/irq_fiq_controller.sv
// Function
// [R1] thirteen channels: six pins, three timers, three uarts, one watchdog
// [R2] or all irq-enabled channels into irq, fiq-enabled into fiq
// [R3] edge channels latch until cleared; level channels follow live input
// [R4] pin channel i trigger type at bit 2i+1, one means edge
// [R5] polarity bit: zero low or falling, one high or rising
// [R6] timer channels always edge, polarity from timer register bits 0..2
// [R7] uarts level active high, watchdog edge, regardless of configuration
// [R8] writing one to clear bit drops edge latch; zero does nothing
// [R9] clear bits 0..8 map channels 0..8, bit 9 clears watchdog
// [R10] irq enable bit i gates channel i; disabled status reads zero
// [R11] fiq enable bit i gates channel i; disabled status reads zero
// [R12] watchdog always routed to fiq; software avoids double enable
// [R13] status registers return channel interrupt anded with enable
// [R14] pending shows channels before masking, latched or live
// [R15] eight registers at offsets 0x00..0x1c, all reset to zero
// [R16] software clears stale latch before enabling an edge channel
// [R17] core samples requests on falling clock edge and synchronises
// [R18] fiq status holds watchdog at bit 12; pending covers bits 12..0
// [R19] pins pass two flip-flops; edges compare current and previous sample
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module irq_fiq_controller (
	input  wire logic                     clock,
	input  wire logic                     rst_b,
	input  wire logic [4:0]               address,
	input  wire logic                     read,
	input  wire logic                     write,
	input  wire logic [31:0]              writedata,
	input  wire logic [3:0]               byteenable,
	output logic      [31:0]              readdata,
	output logic                          waitrequest,
	input  wire irq_fiq_pkg::sources_s    sources,
	output irq_fiq_pkg::requests_s        requests,
	output logic                          irqLine
);
	import irq_fiq_pkg::*;

	// ***********************************
	// registers and sampling
	// ***********************************
	logic [15:0] pinTrigger_r;
	logic [7:0]  timerPol_r;
	logic [11:0] normalEn_r;
	logic [11:0] fastEn_r;
	logic [5:0]  pinMeta_r;
	logic [5:0]  pinSync_r;
	logic [12:0] prev_r;
	logic [12:0] latch_r;
	logic        ack_r;
	logic [31:0] readdata_r;

	logic [12:0] sample;
	logic [12:0] active;
	logic [12:0] isEdge;
	logic [12:0] edgeSeen;
	logic [12:0] clearHit;
	logic [12:0] pending;
	logic [15:0] normalStat;
	logic [15:0] fastStat;
	logic        accessWrite;
	logic [15:0] wordLow;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	// ***********************************
	// channel conditioning
	// ***********************************
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pinMeta_r <= 6'h00;
			pinSync_r <= 6'h00;
		end else begin
			pinMeta_r <= sources.extPins; // [R19]
			pinSync_r <= pinMeta_r; // [R19]
		end
	end

	assign sample = {sources.watchdog, sources.uarts, sources.timers, pinSync_r}; // [R1]

	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
			if (gi < EXT_CHANNELS) begin : g_pin
				assign isEdge[gi] = pinTrigger_r[2*gi+1]; // [R4]
				assign active[gi] = pinTrigger_r[2*gi] ? sample[gi] : ~sample[gi]; // [R5]
			end else if (gi < UART_FIRST) begin : g_timer
				assign isEdge[gi] = 1'b1; // [R6]
				assign active[gi] = timerPol_r[gi-TIMER_FIRST] ? sample[gi]
					: ~sample[gi]; // [R6]
			end else if (gi < WATCHDOG_CH) begin : g_uart
				assign isEdge[gi] = 1'b0; // [R7]
				assign active[gi] = sample[gi]; // [R7]
			end else begin : g_wdog
				assign isEdge[gi] = 1'b1; // [R7]
				assign active[gi] = sample[gi]; // [R7]
			end
		end
	endgenerate

	// polarity folded into active, so a rising active level is the chosen edge
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			prev_r <= 13'h0000;
		end else begin
			prev_r <= active; // [R19]
		end
	end

	assign edgeSeen = active & ~prev_r & isEdge; // [R19]

	// ***********************************
	// bus decode
	// ***********************************
	// a write lands only at the edge where waitrequest is sampled low
	assign accessWrite = write && ack_r; // [R15]
	assign wordLow = writedata[15:0] & {{8{byteenable[1]}}, {8{byteenable[0]}}};
	assign clearHit = (accessWrite && address == OFF_CLEAR)
		? {wordLow[CLEAR_WATCHDOG_BIT], 3'h0, wordLow[8:0]} : 13'h0000; // [R9]

	// set wins over a simultaneous clear
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			latch_r <= 13'h0000;
		end else begin
			latch_r <= ((latch_r & ~clearHit) | edgeSeen) & isEdge; // [R3] [R8]
		end
	end

	assign pending = isEdge & latch_r | ~isEdge & active; // [R3] [R14]
	assign normalStat = {4'h0, pending[11:0] & normalEn_r}; // [R10] [R13]
	assign fastStat = {3'h0, pending[WATCHDOG_CH], pending[11:0] & fastEn_r}; // [R11] [R12] [R18]

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pinTrigger_r <= RESET_VALUE; // [R15]
			timerPol_r <= 8'h00; // [R15]
			normalEn_r <= 12'h000; // [R15]
			fastEn_r <= 12'h000; // [R15]
		end else if (accessWrite) begin
			unique case (address)
				OFF_PIN_TRIGGER: pinTrigger_r <= merge16(pinTrigger_r, writedata, byteenable) & 16'h0fff;
				OFF_TIMER_POL: if (byteenable[0]) timerPol_r <= writedata[7:0] & 8'h07;
				OFF_NORMAL_EN: normalEn_r <= 12'(merge16({4'h0, normalEn_r}, writedata, byteenable));
				OFF_FAST_EN: fastEn_r <= 12'(merge16({4'h0, fastEn_r}, writedata, byteenable));
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
			readdata_r <= 32'h00000000;
		end else begin
			ack_r <= (read || write) && !ack_r;
			if (read && !ack_r) begin
				unique case (address)
					OFF_PIN_TRIGGER: readdata_r <= {16'h0000, pinTrigger_r};
					OFF_TIMER_POL: readdata_r <= {24'h000000, timerPol_r};
					OFF_NORMAL_EN: readdata_r <= {20'h00000, normalEn_r};
					OFF_FAST_EN: readdata_r <= {20'h00000, fastEn_r};
					OFF_NORMAL_STAT: readdata_r <= {16'h0000, normalStat};
					OFF_FAST_STAT: readdata_r <= {16'h0000, fastStat};
					OFF_PENDING: readdata_r <= {19'h00000, pending}; // [R18]
					default: readdata_r <= 32'h00000000;
				endcase
			end
		end
	end

	assign waitrequest = (read || write) && !ack_r;
	assign readdata = readdata_r;

	// ***********************************
	// outputs
	// ***********************************
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			requests <= '0;
		end else begin
			requests.normalReq <= |normalStat; // [R2]
			requests.fastReq <= |fastStat; // [R2] [R12]
		end
	end
	assign irqLine = requests.normalReq | requests.fastReq;

	// ***********************************
	// checks
	// ***********************************
	sequence s_clear_write(int ch);
		accessWrite && address == OFF_CLEAR && wordLow[ch];
	endsequence

	a_normal_or: assert property (@(posedge clock) disable iff (!rst_b) // [R2]
		requests.normalReq == $past(|normalStat)) else $error("irq request mismatch");
	a_fast_watchdog: assert property (@(posedge clock) disable iff (!rst_b) // [R12]
		latch_r[WATCHDOG_CH] |=> requests.fastReq) else $error("watchdog not on fiq");
	a_normal_mask: assert property (@(posedge clock) disable iff (!rst_b) // [R10]
		(normalStat[11:0] & ~normalEn_r) == 12'h000) else $error("irq status unmasked");
	a_fast_mask: assert property (@(posedge clock) disable iff (!rst_b) // [R11]
		(fastStat[11:0] & ~fastEn_r) == 12'h000) else $error("fiq status unmasked");
	a_edge_hold: assert property (@(posedge clock) disable iff (!rst_b) // [R3]
		latch_r[0] && !clearHit[0] |=> latch_r[0] || !isEdge[0]) else $error("latch lost");
	a_clear_works: assert property (@(posedge clock) disable iff (!rst_b) // [R8]
		s_clear_write(3) && !edgeSeen[3] |=> !latch_r[3]) else $error("clear ignored");
	a_clear_wdog: assert property (@(posedge clock) disable iff (!rst_b) // [R9]
		s_clear_write(CLEAR_WATCHDOG_BIT) && !edgeSeen[WATCHDOG_CH] |=> !latch_r[WATCHDOG_CH])
		else $error("watchdog clear ignored");
	a_uart_level: assert property (@(posedge clock) disable iff (!rst_b) // [R7]
		pending[11:9] == sources.uarts) else $error("uart not live");
	a_sync_edge: assert property (@(posedge clock) disable iff (!rst_b) // [R19]
		$rose(pinSync_r[0]) && pinTrigger_r[1:0] == 2'h3 |=> latch_r[0])
		else $error("pin edge missed");
	a_bus_answer: assert property (@(posedge clock) disable iff (!rst_b) // [R15]
		(read || write) && waitrequest |=> !waitrequest) else $error("bus stall");
	a_write_acked: assert property (@(posedge clock) disable iff (!rst_b) // [R15]
		accessWrite |-> !waitrequest) else $error("write taken during wait");
	a_fast_or: assert property (@(posedge clock) disable iff (!rst_b) // [R2]
		requests.fastReq == $past(|fastStat)) else $error("fiq request mismatch");
	a_line_or: assert property (@(posedge clock) disable iff (!rst_b) // [R2]
		irqLine == (requests.normalReq | requests.fastReq)) else $error("line mismatch");
	a_level_live: assert property (@(posedge clock) disable iff (!rst_b) // [R3]
		!isEdge[0] |-> pending[0] == active[0]) else $error("level not live");
	a_wdog_status: assert property (@(posedge clock) disable iff (!rst_b) // [R18]
		fastStat[WATCHDOG_CH] == latch_r[WATCHDOG_CH]) else $error("watchdog status lost");
endmodule : irq_fiq_controller

// >>> logic/irq_fiq_pkg.sv
package irq_fiq_pkg;
	localparam int CHANNELS = 13;
	localparam int EXT_CHANNELS = 6;
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_PIN_TRIGGER = 5'h00;
	localparam logic [4:0] OFF_TIMER_POL = 5'h04;
	localparam logic [4:0] OFF_CLEAR = 5'h08;
	localparam logic [4:0] OFF_NORMAL_EN = 5'h0c;
	localparam logic [4:0] OFF_FAST_EN = 5'h10;
	localparam logic [4:0] OFF_NORMAL_STAT = 5'h14;
	localparam logic [4:0] OFF_FAST_STAT = 5'h18;
	localparam logic [4:0] OFF_PENDING = 5'h1c;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	localparam int TIMER_FIRST = 6;
	localparam int UART_FIRST = 9;
	localparam int WATCHDOG_CH = 12;
	localparam int CLEAR_WATCHDOG_BIT = 9;
	localparam logic [12:0] ROUTABLE_MASK = 13'h0fff;
	localparam logic [12:0] CHANNEL_MASK = 13'h1fff;

	typedef struct packed {
		logic [5:0] extPins;
		logic [2:0] timers;
		logic [2:0] uarts;
		logic       watchdog;
	} sources_s;

	typedef struct packed {
		logic normalReq;
		logic fastReq;
	} requests_s;
endpackage : irq_fiq_pkg

// >>> sim/irq_core_source_model.sv
`timescale 1ns/1ps
module irq_core_source_model (
	input  wire logic                   clock,
	input  wire logic [12:0]            raise,
	input  wire irq_fiq_pkg::requests_s requests,
	output irq_fiq_pkg::sources_s       sources,
	output logic                        irqSeen,
	output logic                        fiqSeen
);
	import irq_fiq_pkg::*;
	// ********
	// sources
	// ********
	// sources move just after a rising edge; uarts copy raise[11:9] and drop only when raise drops
	always @(posedge clock) begin
		sources <= '{extPins: raise[5:0], timers: raise[8:6], uarts: raise[11:9],
			watchdog: raise[12]};
	end
	// ********
	// core
	// ********
	always @(negedge clock) begin
		irqSeen <= requests.normalReq;
		fiqSeen <= requests.fastReq;
	end
endmodule : irq_core_source_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import irq_fiq_pkg::*;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [4:0]  address = 5'h00;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  byteenable = 4'h3;
	logic [31:0] readdata;
	logic [31:0] rdv;
	logic        waitrequest;
	logic        irqLine;
	logic        irqSeen;
	logic        fiqSeen;
	logic [12:0] raise = 13'h01ff;
	sources_s    sources;
	requests_s   requests;
	int          errors = 0;
	int          n_tests = 0;
	int          k;
	irq_fiq_controller u_irq_fiq_controller (.clock(clock), .rst_b(rst_b), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .sources(sources),
		.requests(requests), .irqLine(irqLine));
	irq_core_source_model u_irq_core_source_model (.clock(clock), .raise(raise),
		.requests(requests), .sources(sources), .irqSeen(irqSeen), .fiqSeen(fiqSeen));
	always #2 clock = ~clock;
	task automatic end_of_test;
		if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (waitrequest === 1'b0) break;
		end
		rdv = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (i == 20) begin
			errors++;
			end_of_test();
		end
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rdv, exp);
	endtask : rd
	task automatic drv(input logic [12:0] v);
		@(posedge clock);
		raise <= v;
		repeat (4) @(posedge clock);
	endtask : drv
	// ********
	// scenarios
	// ********
	task automatic t_reset;
		for (k = 0; k < 8; k++) rd(5'(k * 4), 32'h0);
	endtask : t_reset
	task automatic t_regs;
		logic [4:0]  offs [4] = '{OFF_PIN_TRIGGER, OFF_TIMER_POL, OFF_NORMAL_EN, OFF_FAST_EN};
		logic [31:0] lim [4] = '{32'h0fff, 32'h0007, 32'h0fff, 32'h0fff};
		for (k = 0; k < 4; k++) begin
			wr(offs[k], 32'hffff);
			rd(offs[k], lim[k]);
			wr(offs[k], 32'h0);
		end
		wr(OFF_CLEAR, 32'h03ff);
		wr(OFF_PENDING, 32'hffff);
		rd(OFF_PENDING, 32'h0);
		rd(OFF_CLEAR, 32'h0);
	endtask : t_regs
	task automatic t_edge;
		wr(OFF_PIN_TRIGGER, 32'h0080);
		wr(OFF_CLEAR, 32'h03ff);
		wr(OFF_FAST_EN, 32'h0008);
		drv(13'h01f7);
		drv(13'h01ff);
		rd(OFF_PENDING, 32'h0008);
		rd(OFF_FAST_STAT, 32'h0008);
		rd(OFF_NORMAL_STAT, 32'h0);
		chk("fiq", 32'(fiqSeen), 32'h1);
		wr(OFF_CLEAR, 32'h0);
		rd(OFF_PENDING, 32'h0008);
		wr(OFF_CLEAR, 32'h0008);
		rd(OFF_PENDING, 32'h0);
		chk("fiq", 32'(fiqSeen), 32'h0);
		wr(OFF_FAST_EN, 32'h0);
		wr(OFF_PIN_TRIGGER, 32'h0);
	endtask : t_edge
	task automatic t_level;
		wr(OFF_NORMAL_EN, 32'h0400);
		drv(13'h05fe);
		rd(OFF_PENDING, 32'h0401);
		rd(OFF_NORMAL_STAT, 32'h0400);
		wr(OFF_CLEAR, 32'h03ff);
		rd(OFF_PENDING, 32'h0401);
		chk("irq", 32'(irqSeen), 32'h1);
		chk("line", 32'(irqLine), 32'h1);
		drv(13'h01ff);
		rd(OFF_PENDING, 32'h0);
		chk("irq", 32'(irqSeen), 32'h0);
		wr(OFF_NORMAL_EN, 32'h0);
	endtask : t_level
	task automatic t_timer;
		wr(OFF_TIMER_POL, 32'h0002);
		wr(OFF_CLEAR, 32'h03ff);
		drv(13'h017f);
		drv(13'h11ff);
		drv(13'h01ff);
		rd(OFF_PENDING, 32'h1080);
		rd(OFF_FAST_STAT, 32'h1000);
		chk("fiq", 32'(fiqSeen), 32'h1);
		wr(OFF_CLEAR, 32'h0200);
		rd(OFF_PENDING, 32'h0080);
		wr(OFF_CLEAR, 32'h0080);
		rd(OFF_PENDING, 32'h0);
	endtask : t_timer
	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_regs();
		t_edge();
		t_level();
		t_timer();
		end_of_test();
	end
endmodule : testbench
